//--- logic/mpfs_pkg.sv
// Shared constants and types for the motor pre-heat / fire-mode sequencer.
// Assumes a 100 MHz system clock and a word-aligned Avalon-MM slave.
package mpfs_pkg;

  // Time base
  localparam int CLK_HZ            = 100_000_000;         // System clock
  localparam int TICK_MS           = 10;                  // Tick period, ms
  localparam int TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS; // Cycles/tick
  localparam int HEAT_PERIOD_S     = 10;                  // Heat cycle, s
  localparam int HEAT_PERIOD_TICKS = HEAT_PERIOD_S * 1000 / TICK_MS;
  localparam int FIRE_MIN_MINUTES  = 4;                   // Fire count time
  localparam int FIRE_MIN_TICKS    = FIRE_MIN_MINUTES * 60 * 1000 / TICK_MS;

  // Setting limits and reset values
  localparam logic [6:0]  PCT_MAX        = 7'h64;   // 100 percent
  localparam logic [6:0]  HEAT_LEVEL_RST = 7'h00;   // Level after reset
  localparam logic [6:0]  HEAT_DUTY_RST  = 7'h00;   // Duty after reset
  localparam logic [15:0] FIRE_FREQ_MAX  = 16'he9fc; // 599.00 Hz
  localparam logic [15:0] FIRE_FREQ_RST  = 16'h1770; // 60.00 Hz
  localparam logic [7:0]  MF_CODE_RST    = 8'h00;   // No terminal function
  localparam logic [15:0] FIRE_CNT_RST   = 16'h0000; // Activation count

  // Multi-function terminal option codes
  localparam logic [7:0] MFI_AUTO_HEAT = 8'h1a;  // Input option 26
  localparam logic [7:0] MFI_FIRE_NO   = 8'h1b;  // Input option 27, high
  localparam logic [7:0] MFI_FIRE_NC   = 8'h1c;  // Input option 28, low
  localparam logic [7:0] MFO_HEAT_IND  = 8'h18;  // Output option 24
  localparam logic [7:0] MFO_FIRE_IND  = 8'h19;  // Output option 25

  // Fire-mode selector values
  localparam logic [1:0] FIRE_OFF = 2'h0;  // Disabled
  localparam logic [1:0] FIRE_FWD = 2'h1;  // Forward, U-V-W order
  localparam logic [1:0] FIRE_REV = 2'h2;  // Reverse

  // Register byte offsets
  localparam logic [4:0] REG_HEAT_LEVEL = 5'h00;
  localparam logic [4:0] REG_HEAT_DUTY  = 5'h04;
  localparam logic [4:0] REG_FIRE_SEL   = 5'h08;
  localparam logic [4:0] REG_FIRE_FREQ  = 5'h0c;
  localparam logic [4:0] REG_MF_CFG     = 5'h10;
  localparam logic [4:0] REG_STATUS     = 5'h14;
  localparam logic [4:0] REG_FIRE_COUNT = 5'h18;

  // Sequencer states
  typedef enum logic [1:0] {
    MPFS_IDLE = 2'b00,   // No current, no forced run
    MPFS_HEAT = 2'b01,   // Pre-heat cycling
    MPFS_FIRE = 2'b10    // Forced fire-mode run
  } mpfs_state_t;

  // Clamp a written percentage to full scale
  function automatic logic [6:0] clampPct(input logic [7:0] v);
    clampPct = (v > {1'b0, PCT_MAX}) ? PCT_MAX : v[6:0];
  endfunction

  // Merge write data into an old word under byte enables
  function automatic logic [31:0] beMerge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    beMerge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) beMerge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

endpackage

//--- logic/mpfs_tick_gen.sv
// Fixed time-base divider: one-cycle tick every TICK_CYCLES clocks.
// Assumes a free-running system clock; reset restarts the count.
`timescale 1ns/10ps
module mpfs_tick_gen
  import mpfs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES  // Clocks per tick
) (
  input  wire logic clk,     // System clock
  input  wire logic rst_b,   // Async reset, active low
  output logic      tick     // One-cycle tick pulse
);

  localparam int CW = $clog2(TICK_CYCLES_P + 1);  // Counter width
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES_P - 1);

  logic [CW-1:0] cnt_reg;    // Cycle count within tick
  logic [CW-1:0] cnt_next;
  logic          tick_reg;   // Registered tick
  logic          tick_next;

  // Next count; wrap raises the tick
  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next  = tick_next ? '0 : cnt_reg + CW'(1);
  end

  // Counter cleared on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule // mpfs_tick_gen

//--- logic/mpfs_heat_pwm.sv
// Pre-heat duty generator over a repeating cycle of PERIOD_P ticks.
// Assumes duty is 0..100 percent and tick is a one-cycle pulse.
`timescale 1ns/10ps
module mpfs_heat_pwm
  import mpfs_pkg::*;
#(
  parameter int PERIOD_P = HEAT_PERIOD_TICKS  // Ticks per heat cycle
) (
  input  wire logic       clk,     // System clock
  input  wire logic       rst_b,   // Async reset, active low
  input  wire logic       tick,    // Time-base tick
  input  wire logic       enable,  // Pre-heat active
  input  wire logic [6:0] duty,    // Duty, percent
  output logic            on       // Current on, registered
);

  localparam int CW = $clog2(PERIOD_P + 1);  // Counter width
  localparam logic [CW-1:0] LAST = CW'(PERIOD_P - 1);

  logic [CW-1:0] pos_reg;    // Position within cycle
  logic [CW-1:0] pos_next;
  logic          on_reg;     // Registered current enable
  logic          on_next;
  logic [CW-1:0] onTicks;    // On-time in ticks

  // Linear duty-to-time map, 100% equals the whole cycle
  assign onTicks = CW'(int'(duty) * PERIOD_P / 100);

  // Cycle position restarts whenever pre-heat drops
  always_comb begin
    pos_next = pos_reg;
    if (!enable) begin
      pos_next = '0;
    end else if (tick) begin
      pos_next = (pos_reg == LAST) ? '0 : pos_reg + CW'(1);
    end
    // Zero duty never on, full duty always on
    on_next = enable && (pos_next < onTicks);
  end

  // Registers cleared on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg <= '0;
      on_reg  <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      on_reg  <= on_next;
    end
  end

  assign on = on_reg;

endmodule // mpfs_heat_pwm

//--- logic/mpfs_seq.sv
// Top of the motor pre-heat / fire-mode sequencer with Avalon-MM slave.
// Assumes synchronous terminal and drive-state inputs on clk.
`timescale 1ns/10ps
// Contract
// - Heat level is 0..100% of rated current
// - Duty maps linearly to 0..10 s on-time
// - Zero duty no current, full duty continuous
// - Auto-trigger input starts, stops heat
// - Otherwise heat after run ends or power-on
// - Heat while stopped until motor runs again
// - Output option 24 shows heat active
// - Selector: 0 off, 1 forward, 2 reverse
// - Fire needs input 27/28, output 25
// - Fire runs at set frequency, default 60 Hz
// - Count fire activations over four minutes
module mpfs_seq
  import mpfs_pkg::*;
#(
  parameter int TICK_CYCLES_P  = TICK_CYCLES,       // Clocks per tick
  parameter int PERIOD_TICKS_P = HEAT_PERIOD_TICKS, // Ticks per heat cycle
  parameter int FIRE_TICKS_P   = FIRE_MIN_TICKS     // Ticks before count
) (
  input  wire logic        clk,             // System clock
  input  wire logic        rst_b,           // Async reset, active low
  input  wire logic [4:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data, registered
  output logic             avs_waitrequest, // Stall
  input  wire logic        mfiLevel,        // Multi-function input level
  input  wire logic        driveRunning,    // Drive is running the motor
  input  wire logic        powerOnRestart,  // Pulse: power-on restart
  output logic             heatInject,      // Pre-heat DC current on
  output logic      [6:0]  heatLevel,       // DC current, % of rated
  output logic             fireRun,         // Forced fire-mode run
  output logic             fireReverse,     // Fire run direction reverse
  output logic      [15:0] fireFreq,        // Fire frequency, 0.01 Hz
  output logic             relayOut         // Multi-function output relay
);

  localparam int FW = $clog2(FIRE_TICKS_P + 2);  // Fire timer width
  localparam logic [FW-1:0] FIRE_LIMIT = FW'(FIRE_TICKS_P);

  // Software settings
  logic [6:0]  heatLevel_reg;     // Pre-heat level setting
  logic [6:0]  heatLevel_next;
  logic [6:0]  heatDuty_reg;      // Pre-heat duty setting
  logic [6:0]  heatDuty_next;
  logic [1:0]  fireSel_reg;       // Fire-mode selector
  logic [1:0]  fireSel_next;
  logic [15:0] fireFreq_reg;      // Fire-mode frequency
  logic [15:0] fireFreq_next;
  logic [7:0]  mfiCode_reg;       // Input terminal option
  logic [7:0]  mfiCode_next;
  logic [7:0]  mfoCode_reg;       // Output relay option
  logic [7:0]  mfoCode_next;

  // Bus answer state
  logic        rdDone_reg;        // Read data valid this cycle
  logic        rdDone_next;
  logic [31:0] rdData_reg;        // Captured read word
  logic [31:0] rdData_next;
  logic [31:0] wrWord;            // Merged write word

  // Sequencer state
  mpfs_state_t state_reg;         // Current mode
  mpfs_state_t state_next;
  logic        armed_reg;         // Stop-triggered heat armed
  logic        armed_next;
  logic        wasRunning_reg;    // Running, one cycle back
  logic        wasRunning_next;
  logic [FW-1:0] fireTime_reg;    // Fire duration in ticks
  logic [FW-1:0] fireTime_next;
  logic [15:0] fireCount_reg;     // Fire activations counted
  logic [15:0] fireCount_next;

  // Outputs held in flops
  logic        heatLevelOut_reg;  // Level output gate
  logic        fireRun_reg;
  logic        fireRun_next;
  logic        fireRev_reg;
  logic        fireRev_next;
  logic [15:0] fireFreqOut_reg;
  logic [15:0] fireFreqOut_next;
  logic        relay_reg;
  logic        relay_next;
  logic        levelGate_next;

  // Derived conditions
  logic        tick;              // Time-base tick
  logic        heatOn;            // Duty generator output
  logic        heatAllowed;       // Both settings non-zero
  logic        autoAssigned;      // Input carries auto-trigger
  logic        fireInAssigned;    // Input carries fire option
  logic        fireCfgOk;         // Terminals set up for fire
  logic        fireDemand;        // Fire requested now
  logic        heatDemand;        // Pre-heat requested now
  logic        heatActive;        // In heat state

  // Shared time base
  mpfs_tick_gen #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .tick  (tick)
  );

  // Duty-cycle generator for the DC current
  mpfs_heat_pwm #(
    .PERIOD_P (PERIOD_TICKS_P)
  ) u_pwm (
    .clk    (clk),
    .rst_b  (rst_b),
    .tick   (tick),
    .enable (levelGate_next),
    .duty   (heatDuty_reg),
    .on     (heatOn)
  );

  // Reads take one wait cycle so data comes from a flop
  assign avs_waitrequest = avs_read && !rdDone_reg;
  assign avs_readdata    = rdData_reg;

  // Word currently stored at the addressed offset, for merging
  always_comb begin
    case (avs_address)
      REG_HEAT_LEVEL: wrWord = {25'h0, heatLevel_reg};
      REG_HEAT_DUTY:  wrWord = {25'h0, heatDuty_reg};
      REG_FIRE_SEL:   wrWord = {30'h0, fireSel_reg};
      REG_FIRE_FREQ:  wrWord = {16'h0, fireFreq_reg};
      REG_MF_CFG:     wrWord = {16'h0, mfoCode_reg, mfiCode_reg};
      default:        wrWord = 32'h0;
    endcase
    wrWord = beMerge(wrWord, avs_writedata, avs_byteenable);
  end

  // Settings written in the cycle of the request; no wait for writes
  always_comb begin
    heatLevel_next = heatLevel_reg;
    heatDuty_next  = heatDuty_reg;
    fireSel_next   = fireSel_reg;
    fireFreq_next  = fireFreq_reg;
    mfiCode_next   = mfiCode_reg;
    mfoCode_next   = mfoCode_reg;
    if (avs_write) begin
      case (avs_address)
        REG_HEAT_LEVEL: heatLevel_next = clampPct(wrWord[7:0]);
        REG_HEAT_DUTY:  heatDuty_next  = clampPct(wrWord[7:0]);
        REG_FIRE_SEL:   fireSel_next   = wrWord[1:0];
        REG_FIRE_FREQ: begin
          // Above 599.00 Hz is held at the limit
          fireFreq_next = (wrWord[15:0] > FIRE_FREQ_MAX) ?
                          FIRE_FREQ_MAX : wrWord[15:0];
        end
        REG_MF_CFG: begin
          mfiCode_next = wrWord[7:0];
          mfoCode_next = wrWord[15:8];
        end
        // Status and count are read-only; writes vanish
        default: ;
      endcase
    end
  end

  // Read capture; unmapped offsets answer zero
  always_comb begin
    rdDone_next = avs_read && !rdDone_reg;
    rdData_next = rdData_reg;
    if (avs_read && !rdDone_reg) begin
      case (avs_address)
        REG_HEAT_LEVEL: rdData_next = {25'h0, heatLevel_reg};
        REG_HEAT_DUTY:  rdData_next = {25'h0, heatDuty_reg};
        REG_FIRE_SEL:   rdData_next = {30'h0, fireSel_reg};
        REG_FIRE_FREQ:  rdData_next = {16'h0, fireFreq_reg};
        REG_MF_CFG:     rdData_next = {16'h0, mfoCode_reg, mfiCode_reg};
        REG_STATUS: begin
          rdData_next = {27'h0, fireRev_reg, fireRun_reg, heatInject,
                         heatActive, driveRunning};
        end
        REG_FIRE_COUNT: rdData_next = {16'h0, fireCount_reg};
        default:        rdData_next = 32'h0;
      endcase
    end
  end

  // Settings and bus registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      heatLevel_reg <= HEAT_LEVEL_RST;
      heatDuty_reg  <= HEAT_DUTY_RST;
      fireSel_reg   <= FIRE_OFF;
      fireFreq_reg  <= FIRE_FREQ_RST;
      mfiCode_reg   <= MF_CODE_RST;
      mfoCode_reg   <= MF_CODE_RST;
      rdDone_reg    <= 1'b0;
      rdData_reg    <= 32'h0;
    end else begin
      heatLevel_reg <= heatLevel_next;
      heatDuty_reg  <= heatDuty_next;
      fireSel_reg   <= fireSel_next;
      fireFreq_reg  <= fireFreq_next;
      mfiCode_reg   <= mfiCode_next;
      mfoCode_reg   <= mfoCode_next;
      rdDone_reg    <= rdDone_next;
      rdData_reg    <= rdData_next;
    end
  end

  // Terminal decode and demands
  always_comb begin
    heatAllowed    = (heatLevel_reg != 7'h00) &&
                     (heatDuty_reg != 7'h00);
    autoAssigned   = (mfiCode_reg == MFI_AUTO_HEAT);
    fireInAssigned = (mfiCode_reg == MFI_FIRE_NO) ||
                     (mfiCode_reg == MFI_FIRE_NC);
    // Fire needs both terminals configured
    fireCfgOk      = fireInAssigned && (mfoCode_reg == MFO_FIRE_IND);
    // Option 27 is a make contact, 28 a break contact
    fireDemand     = fireCfgOk &&
                     ((fireSel_reg == FIRE_FWD) ||
                      (fireSel_reg == FIRE_REV)) &&
                     ((mfiCode_reg == MFI_FIRE_NO) ? mfiLevel : !mfiLevel);
    // Auto-trigger input governs heat when assigned
    if (autoAssigned) begin
      heatDemand = heatAllowed && mfiLevel && !driveRunning;
    end else begin
      heatDemand = heatAllowed && armed_reg && !driveRunning;
    end
  end

  // Arming for the non-triggered case: end of a run, or power-on restart
  always_comb begin
    wasRunning_next = driveRunning;
    armed_next      = armed_reg;
    if (driveRunning) begin
      armed_next = 1'b0;
    end else if ((wasRunning_reg && !driveRunning) || powerOnRestart) begin
      armed_next = 1'b1;
    end
  end

  // Mode selection; fire mode overrides pre-heat
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MPFS_IDLE: begin
        if (fireDemand)      state_next = MPFS_FIRE;
        else if (heatDemand) state_next = MPFS_HEAT;
      end
      MPFS_HEAT: begin
        if (fireDemand)       state_next = MPFS_FIRE;
        else if (!heatDemand) state_next = MPFS_IDLE;
      end
      MPFS_FIRE: begin
        if (!fireDemand) state_next = MPFS_IDLE;
      end
      default: state_next = MPFS_IDLE;
    endcase
  end

  assign heatActive = (state_reg == MPFS_HEAT);

  // Fire duration timer and activation counter
  always_comb begin
    fireTime_next  = fireTime_reg;
    fireCount_next = fireCount_reg;
    if (state_reg != MPFS_FIRE) begin
      fireTime_next = '0;
    end else if (tick && (fireTime_reg <= FIRE_LIMIT)) begin
      // Counter stops one past the limit so each activation counts once
      fireTime_next = fireTime_reg + FW'(1);
      if (fireTime_reg == FIRE_LIMIT) begin
        // Saturates rather than wrapping back to zero
        if (fireCount_reg != 16'hffff) begin
          fireCount_next = fireCount_reg + 16'h0001;
        end
      end
    end
  end

  // Output values for the next cycle
  always_comb begin
    fireRun_next     = (state_next == MPFS_FIRE);
    fireRev_next     = (state_next == MPFS_FIRE) &&
                       (fireSel_reg == FIRE_REV);
    fireFreqOut_next = (state_next == MPFS_FIRE) ? fireFreq_reg : 16'h0000;
    levelGate_next   = (state_next == MPFS_HEAT);
    // Relay follows whichever option is assigned to it
    case (mfoCode_reg)
      MFO_HEAT_IND: relay_next = (state_next == MPFS_HEAT);
      MFO_FIRE_IND: relay_next = (state_next == MPFS_FIRE);
      default:      relay_next = 1'b0;
    endcase
  end

  // Sequencer and output registers; timers clear on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg        <= MPFS_IDLE;
      armed_reg        <= 1'b0;
      wasRunning_reg   <= 1'b0;
      fireTime_reg     <= '0;
      fireCount_reg    <= FIRE_CNT_RST;
      heatLevelOut_reg <= 1'b0;
      fireRun_reg      <= 1'b0;
      fireRev_reg      <= 1'b0;
      fireFreqOut_reg  <= 16'h0000;
      relay_reg        <= 1'b0;
    end else begin
      state_reg        <= state_next;
      armed_reg        <= armed_next;
      wasRunning_reg   <= wasRunning_next;
      fireTime_reg     <= fireTime_next;
      fireCount_reg    <= fireCount_next;
      heatLevelOut_reg <= levelGate_next;
      fireRun_reg      <= fireRun_next;
      fireRev_reg      <= fireRev_next;
      fireFreqOut_reg  <= fireFreqOut_next;
      relay_reg        <= relay_next;
    end
  end

  // Current flows only in the on part of the cycle
  assign heatInject  = heatOn;
  // Level is zero outside pre-heat so no stray current is requested
  assign heatLevel   = heatLevelOut_reg ? heatLevel_reg : 7'h00;
  assign fireRun     = fireRun_reg;
  assign fireReverse = fireRev_reg;
  assign fireFreq    = fireFreqOut_reg;
  assign relayOut    = relay_reg;

endmodule // mpfs_seq

//--- testbench/mpfs_seq_checker.sv
// Port assertions for the pre-heat / fire-mode sequencer.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
module mpfs_seq_checker
  import mpfs_pkg::*;
(
  input wire logic        clk,             // System clock
  input wire logic        rst_b,           // Reset, active low
  input wire logic        avs_read,        // Read strobe
  input wire logic        avs_write,       // Write strobe
  input wire logic        avs_waitrequest, // Stall
  input wire logic        driveRunning,    // Drive runs motor
  input wire logic        heatInject,      // DC current on
  input wire logic [6:0]  heatLevel,       // DC level
  input wire logic        fireRun,         // Forced run
  input wire logic        fireReverse,     // Reverse direction
  input wire logic [15:0] fireFreq,        // Fire frequency
  input wire logic        relayOut         // Relay
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Writes complete at once
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  // Reads take exactly one wait
  a_read_onewait: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
  a_level_max: assert property (heatLevel <= PCT_MAX)
    else $error("level above full scale");
  a_inject_level: assert property (heatInject |->
    heatLevel != 7'h00) else $error("current with zero level");
  // Margin covers demand, state and output stages
  a_run_noheat: assert property (driveRunning [*5] |->
    !heatInject && heatLevel == 7'h00) else $error("heat while running");
  a_freq_max: assert property (fireRun |->
    fireFreq <= FIRE_FREQ_MAX) else $error("fire frequency too high");
  a_freq_off: assert property (!fireRun |->
    fireFreq == 16'h0000) else $error("frequency without fire");
  a_fire_excl: assert property (fireRun |->
    heatLevel == 7'h00) else $error("heat during fire");
  // Outputs clear whenever reset is held
  a_reset_clear: assert property (disable iff (1'b0) !rst_b |->
    !heatInject && !fireRun && !relayOut && heatLevel == 7'h00)
    else $error("outputs live in reset");
  c_heat: cover property ($rose(heatInject));
  c_reverse: cover property (fireRun && fireReverse);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // mpfs_seq_checker

bind mpfs_seq mpfs_seq_checker chk_u (.clk(clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .driveRunning(driveRunning),
  .heatInject(heatInject), .heatLevel(heatLevel), .fireRun(fireRun),
  .fireReverse(fireReverse), .fireFreq(fireFreq), .relayOut(relayOut));

//--- testbench/mpfs_field_model.sv
// Field side: input terminal, drive run state, power-on event, motor.
// Assumes bench commands; each takes effect at the next rising edge.
`timescale 1ns/10ps
module mpfs_field_model (
  input  wire logic clk,            // System clock
  input  wire logic cmdMfi,         // Wanted terminal level
  input  wire logic cmdRun,         // Wanted run state
  input  wire logic cmdPor,         // Power-on request, level
  input  wire logic heatInject,     // Current into the motor
  output logic      mfiLevel,       // Terminal level
  output logic      driveRunning,   // Drive runs motor
  output logic      powerOnRestart, // One-cycle event
  output int        heatCycles      // Cycles with current on
);
  logic porSeen; // Last request level
  initial begin
    mfiLevel = 1'b0;
    driveRunning = 1'b0;
    powerOnRestart = 1'b0;
    heatCycles = 0;
    porSeen = 1'b0;
  end
  // Terminals move only on edges; the event is a single pulse
  always @(posedge clk) begin
    mfiLevel <= cmdMfi;
    driveRunning <= cmdRun;
    powerOnRestart <= cmdPor && !porSeen;
    porSeen <= cmdPor;
    if (heatInject === 1'b1) begin
      heatCycles <= heatCycles + 1; // Motor warms
    end
  end
endmodule // mpfs_field_model

//--- testbench/testbench.sv
// Self-checking bench for the pre-heat / fire-mode sequencer.
// Assumes shortened tick, heat period and fire time parameters.
`timescale 1ns/10ps
module testbench;
  import mpfs_pkg::*;
  logic        clk, rst_b, avsRead, avsWrite; // Clock, reset, strobes
  logic [4:0]  avsAddr;                       // Address
  logic [31:0] avsWdata, avsRdata, seed;      // Bus data, random state
  logic [3:0]  avsBe;                         // Byte lanes
  logic        avsWait, mfi, run, por;        // Stall, field lines
  logic        cMfi, cRun, cPor, on;          // Commands, expectation
  logic        heatInject, fireRun, fireRev, relayOut; // Outputs
  logic [6:0]  heatLevel, v;                  // DC level
  logic [15:0] fireFreq;                      // Fire frequency
  int          heatCycles, num_errors, n_compared, t0; // Counters
  logic [31:0] expQ[$];                       // Expected read data
  int hl[5] = '{40, 0, 40, 40, 40};           // Heat level table
  int hd[5] = '{0, 50, 30, 50, 100};          // Heat duty table
  logic [31:0] fc[5] = '{32'h191b, 32'h191b, 32'h191b, 32'h181b, 32'h191c};
  int fs[5] = '{0, 1, 2, 1, 1};               // Fire selector
  logic fm[5] = '{1, 1, 1, 1, 0};             // Terminal level
  int fh[5] = '{40, 40, 12, 12, 12};          // Activation cycles

  mpfs_seq #(.TICK_CYCLES_P(4), .PERIOD_TICKS_P(10), .FIRE_TICKS_P(5))
    dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_byteenable(avsBe), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .mfiLevel(mfi), .driveRunning(run),
    .powerOnRestart(por), .heatInject(heatInject), .heatLevel(heatLevel),
    .fireRun(fireRun), .fireReverse(fireRev), .fireFreq(fireFreq),
    .relayOut(relayOut));
  mpfs_field_model field_u (.clk(clk), .cmdMfi(cMfi), .cmdRun(cRun),
    .cmdPor(cPor), .heatInject(heatInject), .mfiLevel(mfi),
    .driveRunning(run), .powerOnRestart(por), .heatCycles(heatCycles));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One bus cycle, entered just after a rising edge
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [3:0] b);
    int n;
    avsAddr <= a;
    avsWdata <= d;
    avsBe <= b;
    if (w) avsWrite <= 1'b1;
    else avsRead <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWait !== 1'b0 && n < 50);
    if (avsWait !== 1'b0) begin
      num_errors++;
      close_out();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(logic [4:0] a, logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(logic [4:0] a, logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // Takes the oldest note whenever read data is handed over
  always @(posedge clk) begin
    if (avsRead && avsWait === 1'b0 && expQ.size() > 0) begin
      chk("readdata", avsRdata, expQ.pop_front());
    end
  end

  initial begin
    {rst_b, avsRead, avsWrite, cMfi, cRun, cPor} <= 6'h00;
    avsAddr = 5'h00;
    avsWdata = 32'h0;
    avsBe = 4'h0;
    num_errors = 0;
    n_compared = 0;
    seed = 32'h08da;
    cyc(16);
    rst_b <= 1'b1;
    cyc(1);
    // Reset values, unmapped address reads zero
    rd(REG_HEAT_LEVEL, 32'h0);
    rd(REG_FIRE_FREQ, 32'h1770);
    rd(REG_FIRE_COUNT, 32'h0);
    rd(5'h1c, 32'h0);
    // Random levels, above full scale clamps
    repeat (4) begin
      seed = xs(seed);
      wr(REG_HEAT_LEVEL, {24'h0, seed[7:0]});
      v = (seed[7:0] > 8'h64) ? 7'h64 : seed[6:0];
      rd(REG_HEAT_LEVEL, {25'h0, v});
    end
    wr(REG_FIRE_FREQ, 32'hffff);
    rd(REG_FIRE_FREQ, 32'he9fc);
    bus(1'b1, REG_FIRE_FREQ, 32'h12, 4'h1);
    rd(REG_FIRE_FREQ, 32'he912);
    // Auto-trigger heat across level and duty corners
    wr(REG_MF_CFG, 32'h181a);
    for (int i = 0; i < 5; i++) begin
      wr(REG_HEAT_LEVEL, hl[i]);
      wr(REG_HEAT_DUTY, hd[i]);
      cMfi <= 1'b1;
      cyc(50);
      t0 = heatCycles;
      cyc(40);
      on = hl[i] != 0 && hd[i] != 0;
      chk("onTime", heatCycles - t0, on ? hd[i] * 4 / 10 : 0);
      chk("heatLevel", heatLevel, on ? hl[i] : 0);
      chk("relay", relayOut, on);
      cRun <= 1'b1;
      cyc(6);
      chk("heatLevel", heatLevel, 32'h0);
      cRun <= 1'b0;
      cMfi <= 1'b0;
      cyc(6);
      chk("heatInject", heatInject, 32'h0);
    end
    // Mid-run reset, then heat without the trigger input
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(1);
    wr(REG_MF_CFG, 32'h1800);
    wr(REG_HEAT_LEVEL, 32'h28);
    wr(REG_HEAT_DUTY, 32'h64);
    cyc(6);
    chk("heatLevel", heatLevel, 32'h0);
    cPor <= 1'b1;
    cyc(6);
    chk("heatLevel", heatLevel, 32'h28);
    cRun <= 1'b1;
    cyc(6);
    chk("heatLevel", heatLevel, 32'h0);
    cRun <= 1'b0;
    cyc(6);
    chk("heatLevel", heatLevel, 32'h28);
    chk("heatInject", heatInject, 32'h1);
    rd(REG_STATUS, 32'h6);
    cRun <= 1'b1;
    // Fire selector, terminal options, activation count
    for (int i = 0; i < 5; i++) begin
      wr(REG_MF_CFG, fc[i]);
      wr(REG_FIRE_SEL, fs[i]);
      cMfi <= fm[i];
      cyc(fh[i]);
      on = fs[i] != 0 && fc[i][15:8] == 8'h19;
      chk("fireRun", fireRun, on);
      chk("fireRev", fireRev, on && fs[i] == 2);
      chk("fireFreq", fireFreq, on ? 32'h1770 : 0);
      chk("relay", relayOut, on);
      wr(REG_FIRE_SEL, 32'h0);
      cyc(4);
      wr(REG_FIRE_COUNT, 32'hffff);
      rd(REG_FIRE_COUNT, i > 0);
    end
    close_out();
  end
endmodule // testbench
